// File: power_state_pkg.sv
// Constants, types and register map of the power-state controller with I2C slave
// How it works
// (RULE_01) Device answers as I2C slave at seven-bit address 0x5A.
// (RULE_02) Eighth address bit picks direction: 0 write (0xB4), 1 read (0xB5).
// (RULE_03) No timeout; every start condition restarts packet processing.
// (RULE_04) I2C engine held in reset outside the active state.
// (RULE_05) SCL and SDA glitches up to 50 ns are filtered out.
// (RULE_06) SDA only pulled low or released, open-drain.
// (RULE_07) Volatile read-write registers reset to fixed constant defaults.
// (RULE_08) Factory-configurable registers reset to factory-programmed defaults.
// (RULE_09) Host changes partial fields by read-modify-write.
// (RULE_10) Power controller has exactly five states.
// (RULE_11) Reset state: regulators off, three reset outputs low, wait input window.
// (RULE_12) Reset state restores volatile and factory defaults.
// (RULE_13) Reset goes to active once input voltage is valid.
// (RULE_14) Undervoltage lockout returns any other state to reset.
// (RULE_15) Active from reset is sequenced; active from sleep is not.
// (RULE_16) Sleep outputs follow own sleep enable, unsequenced, with soft-start.
// (RULE_17) In sleep bucks use primary, alternate or off; linears primary or off.
// (RULE_18) Sleep entered from sleep control pin or an I2C register command.
// (RULE_19) Host sets source select and sleep permission before I2C sleep.
// (RULE_20) Writing 1 to sleep request bit enters sleep when I2C sleep enabled.
// (RULE_21) I2C disabled in sleep; only a sleep pin toggle exits sleep. The code also leaves sleep on thermal shutdown and on undervoltage lockout.
// (RULE_22) Output fault: all off, resets low, retry active after 100 ms.
// (RULE_23) Thermal shutdown: enter thermal state, all off, resets low.
// (RULE_24) Write: index then data; read via repeated start from indexed register.
// (RULE_25) Acknowledge own address and each received byte; release SDA otherwise.
`default_nettype none
package power_state_pkg;

	// ----------------------------------------------------------------
	// Bus and timing
	// ----------------------------------------------------------------
	localparam logic [6:0]  DEV_ADDR      = 7'h5a;
	localparam int          CLK_PERIOD_NS = 20;
	localparam int          GLITCH_NS     = 50;
	localparam int          FILT_CYC      = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int          RETRY_MS      = 100;
	localparam int          RETRY_CYC     = RETRY_MS * 1000000 / CLK_PERIOD_NS;
	localparam int          NUM_OUT       = 7;
	localparam int          NUM_BUCK      = 4;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFS_POWER_MODE_CONTROL = 8'h00;
	localparam logic [7:0]  OFS_SLEEP_COMMAND      = 8'h01;
	localparam logic [7:0]  OFS_SLEEP_OUT_ENABLE   = 8'h02;
	localparam logic [7:0]  OFS_SLEEP_ALT_SELECT   = 8'h03;
	localparam logic [7:0]  OFS_POWER_STATUS       = 8'h04;
	localparam logic [7:0]  OFS_POWER_DOWN_CONFIG  = 8'h08;
	localparam int          BIT_SLEEP_PERMISSION   = 0;
	localparam int          BIT_SLEEP_REQUEST      = 1;
	localparam int          BIT_SOURCE_SELECT      = 1;
	localparam logic [7:0]  RST_POWER_MODE_CONTROL = 8'h00;
	localparam logic [7:0]  RST_SLEEP_COMMAND      = 8'h00;
	localparam logic [7:0]  RST_FACTORY_BYTE       = 8'h00;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		P_RESET   = 3'b000,
		P_ACTIVE  = 3'b001,
		P_SLEEP   = 3'b010,
		P_FAULT   = 3'b011,
		P_THERMAL = 3'b100
	} pwr_state_e;

	typedef enum logic [3:0] {
		S_IDLE  = 4'b0000,
		S_ADDR  = 4'b0001,
		S_AACK  = 4'b0010,
		S_INDEX = 4'b0011,
		S_IACK  = 4'b0100,
		S_WRITE = 4'b0101,
		S_WACK  = 4'b0110,
		S_READ  = 4'b0111,
		S_RACK  = 4'b1000
	} i2c_state_e;

	typedef struct packed {
		logic [7:0]          power_down_config;
		logic [NUM_OUT-1:0]  sleep_out_enable;
		logic [NUM_BUCK-1:0] sleep_alt_select;
	} factory_cfg_s;

	typedef struct packed {
		logic [NUM_OUT-1:0]  reg_enable;
		logic [NUM_BUCK-1:0] alt_voltage;
		logic                seq_start;
	} pwr_out_s;

endpackage

`default_nettype wire

// File: power_state_i2c_slave.sv
// Power-state controller with glitch filters and I2C register slave
`timescale 1ns/100ps
`default_nettype none

// --------------------------------------------------------------------
// Glitch filter: output follows input only after it is stable
// --------------------------------------------------------------------
module glitch_filter #(
	parameter int CYC = 4
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic din,
	output var  logic dout
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic       out_q;
	logic       out_d;

	assign dout = out_q;

	always_comb begin
		cnt_d = 8'h00;
		out_d = out_q;
		if (din != out_q) begin
			cnt_d = cnt_q + 8'h01;
			if (cnt_d >= 8'(CYC)) begin
				out_d = din;
				cnt_d = 8'h00;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 8'h00;
			out_q <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end
endmodule

// --------------------------------------------------------------------
// Top
// --------------------------------------------------------------------
module power_state_i2c_slave
	import power_state_pkg::*;
#(
	parameter int RETRY_CYCLES = power_state_pkg::RETRY_CYC
) (
	// Clock and reset
	input  wire logic                         CLK_SYS,
	input  wire logic                         RST,
	// I2C pins
	input  wire logic                         SCL_I,
	input  wire logic                         SDA_I,
	output var  logic                         SDA_O,
	output var  logic                         SDA_OE,
	// Monitors and control pin
	input  wire logic                         VIN_VALID,
	input  wire logic                         VIN_UVLO,
	input  wire logic                         OUTPUT_FAULT,
	input  wire logic                         THERMAL_SHUTDOWN,
	input  wire logic                         SLEEP_CONTROL_PIN,
	input  wire power_state_pkg::factory_cfg_s FACTORY_CFG,
	// Power outputs
	output var  power_state_pkg::pwr_out_s     PWR_OUT,
	output var  logic                         MAIN_RESET_OUT_N,
	output var  logic                         AUX_RESET_ONE_OUT_N,
	output var  logic                         AUX_RESET_TWO_OUT_N,
	output var  logic [2:0]                   POWER_STATE
);
	import power_state_pkg::*;

	// ----------------------------------------------------------------
	// Input filters
	// ----------------------------------------------------------------
	logic scl_f;
	logic sda_f;

	glitch_filter #(.CYC(FILT_CYC)) u_scl_filt ( // RULE_05
		.clk  (CLK_SYS),
		.rst  (RST),
		.din  (SCL_I),
		.dout (scl_f)
	);
	glitch_filter #(.CYC(FILT_CYC)) u_sda_filt ( // RULE_05
		.clk  (CLK_SYS),
		.rst  (RST),
		.din  (SDA_I),
		.dout (sda_f)
	);

	logic scl_q;
	logic sda_q;
	logic pin_q;
	logic scl_rise;
	logic scl_fall;
	logic i2c_start;
	logic i2c_stop;

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			pin_q <= 1'b1;
		end else begin
			scl_q <= scl_f;
			sda_q <= sda_f;
			pin_q <= SLEEP_CONTROL_PIN;
		end
	end

	assign scl_rise  = scl_f & ~scl_q;
	assign scl_fall  = ~scl_f & scl_q;
	assign i2c_start = scl_f & scl_q & sda_q & ~sda_f;
	assign i2c_stop  = scl_f & scl_q & ~sda_q & sda_f;

	// ----------------------------------------------------------------
	// I2C engine
	// ----------------------------------------------------------------
	pwr_state_e state_q;
	i2c_state_e ist_q;
	i2c_state_e ist_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic [7:0] idx_q;
	logic [7:0] idx_d;
	logic [7:0] tx_q;
	logic [7:0] tx_d;
	logic       rw_q;
	logic       rw_d;
	logic       nack_q;
	logic       nack_d;
	logic       oe_q;
	logic       oe_d;
	logic       wr_en;
	logic [7:0] rd_data;

	always_comb begin
		ist_d  = ist_q;
		cnt_d  = cnt_q;
		sh_d   = sh_q;
		idx_d  = idx_q;
		tx_d   = tx_q;
		rw_d   = rw_q;
		nack_d = nack_q;
		oe_d   = oe_q;
		wr_en  = 1'b0;
		if (state_q != P_ACTIVE) begin // RULE_04 RULE_21
			ist_d = S_IDLE;
			oe_d  = 1'b0;
			cnt_d = 4'h0;
		end else if (i2c_start) begin // RULE_03
			ist_d = S_ADDR;
			cnt_d = 4'h0;
			oe_d  = 1'b0;
		end else if (i2c_stop) begin
			ist_d = S_IDLE;
			oe_d  = 1'b0;
		end else begin
			if (scl_rise && ist_q inside {S_ADDR, S_INDEX, S_WRITE}) begin
				sh_d  = {sh_q[6:0], sda_f};
				cnt_d = cnt_q + 4'h1;
			end
			case (ist_q)
				S_IDLE: begin
					oe_d = 1'b0;
				end
				S_ADDR: begin
					if (scl_fall && cnt_q == 4'h8) begin
						if (sh_q[7:1] == DEV_ADDR) begin // RULE_01 RULE_25
							rw_d  = sh_q[0]; // RULE_02
							oe_d  = 1'b1;
							ist_d = S_AACK;
						end else begin
							ist_d = S_IDLE;
						end
					end
				end
				S_AACK: begin
					if (scl_fall) begin
						cnt_d = 4'h0;
						if (rw_q) begin // RULE_24
							tx_d  = rd_data;
							oe_d  = ~rd_data[7];
							idx_d = idx_q + 8'h01;
							ist_d = S_READ;
						end else begin
							oe_d  = 1'b0;
							ist_d = S_INDEX;
						end
					end
				end
				S_INDEX: begin
					if (scl_fall && cnt_q == 4'h8) begin
						idx_d = sh_q; // RULE_24
						oe_d  = 1'b1; // RULE_25
						ist_d = S_IACK;
					end
				end
				S_IACK, S_WACK: begin
					if (scl_fall) begin
						oe_d  = 1'b0;
						cnt_d = 4'h0;
						ist_d = S_WRITE;
					end
				end
				S_WRITE: begin
					if (scl_fall && cnt_q == 4'h8) begin
						wr_en = 1'b1;
						oe_d  = 1'b1; // RULE_25
						ist_d = S_WACK;
					end
				end
				S_READ: begin
					if (scl_rise) begin
						cnt_d = cnt_q + 4'h1;
					end
					if (scl_fall) begin
						if (cnt_q == 4'h8) begin
							oe_d  = 1'b0;
							ist_d = S_RACK;
						end else begin
							tx_d = {tx_q[6:0], 1'b0};
							oe_d = ~tx_q[6]; // RULE_06
						end
					end
				end
				S_RACK: begin
					if (scl_rise) begin
						nack_d = sda_f;
					end
					if (scl_fall) begin
						cnt_d = 4'h0;
						if (nack_q) begin
							ist_d = S_IDLE;
						end else begin
							tx_d  = rd_data;
							oe_d  = ~rd_data[7];
							idx_d = idx_q + 8'h01;
							ist_d = S_READ;
						end
					end
				end
				default: begin
					ist_d = S_IDLE;
					oe_d  = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ist_q  <= S_IDLE;
			cnt_q  <= 4'h0;
			sh_q   <= 8'h00;
			idx_q  <= 8'h00;
			tx_q   <= 8'h00;
			rw_q   <= 1'b0;
			nack_q <= 1'b0;
			oe_q   <= 1'b0;
		end else begin
			ist_q  <= ist_d;
			cnt_q  <= cnt_d;
			sh_q   <= sh_d;
			idx_q  <= idx_d;
			tx_q   <= tx_d;
			rw_q   <= rw_d;
			nack_q <= nack_d;
			oe_q   <= oe_d;
		end
	end

	// Open drain: the data value is always low, only the enable moves
	assign SDA_OE = oe_q; // RULE_06
	assign SDA_O  = 1'b0;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [7:0]          pmc_q;
	logic [7:0]          pmc_d;
	logic [7:0]          scmd_q;
	logic [7:0]          scmd_d;
	logic [7:0]          pdc_q;
	logic [7:0]          pdc_d;
	logic [NUM_OUT-1:0]  slp_en_q;
	logic [NUM_OUT-1:0]  slp_en_d;
	logic [NUM_BUCK-1:0] slp_alt_q;
	logic [NUM_BUCK-1:0] slp_alt_d;
	logic                enter_sleep;

	always_comb begin
		case (idx_q)
			OFS_POWER_MODE_CONTROL: rd_data = pmc_q;
			OFS_SLEEP_COMMAND:      rd_data = scmd_q;
			OFS_SLEEP_OUT_ENABLE:   rd_data = {1'b0, slp_en_q};
			OFS_SLEEP_ALT_SELECT:   rd_data = {4'h0, slp_alt_q};
			OFS_POWER_STATUS:       rd_data = {5'h00, state_q};
			OFS_POWER_DOWN_CONFIG:  rd_data = pdc_q;
			default:                rd_data = 8'h00;
		endcase
	end

	always_comb begin
		pmc_d     = pmc_q;
		scmd_d    = scmd_q;
		pdc_d     = pdc_q;
		slp_en_d  = slp_en_q;
		slp_alt_d = slp_alt_q;
		if (state_q == P_RESET) begin // RULE_12
			pmc_d     = RST_POWER_MODE_CONTROL; // RULE_07
			scmd_d    = RST_SLEEP_COMMAND; // RULE_07
			pdc_d     = FACTORY_CFG.power_down_config; // RULE_08
			slp_en_d  = FACTORY_CFG.sleep_out_enable; // RULE_08
			slp_alt_d = FACTORY_CFG.sleep_alt_select; // RULE_08
		end else begin
			if (enter_sleep) begin
				scmd_d[BIT_SLEEP_REQUEST] = 1'b0;
			end
			if (wr_en) begin
				case (idx_q)
					OFS_POWER_MODE_CONTROL: pmc_d     = sh_q;
					OFS_SLEEP_COMMAND:      scmd_d    = sh_q;
					OFS_SLEEP_OUT_ENABLE:   slp_en_d  = sh_q[NUM_OUT-1:0];
					OFS_SLEEP_ALT_SELECT:   slp_alt_d = sh_q[NUM_BUCK-1:0];
					OFS_POWER_DOWN_CONFIG:  pdc_d     = sh_q;
					default:                pmc_d     = pmc_q;
				endcase
			end
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			pmc_q     <= RST_POWER_MODE_CONTROL;
			scmd_q    <= RST_SLEEP_COMMAND;
			pdc_q     <= RST_FACTORY_BYTE;
			slp_en_q  <= RST_FACTORY_BYTE[NUM_OUT-1:0];
			slp_alt_q <= RST_FACTORY_BYTE[NUM_BUCK-1:0];
		end else begin
			pmc_q     <= pmc_d;
			scmd_q    <= scmd_d;
			pdc_q     <= pdc_d;
			slp_en_q  <= slp_en_d;
			slp_alt_q <= slp_alt_d;
		end
	end

	// ----------------------------------------------------------------
	// Power state machine
	// ----------------------------------------------------------------
	pwr_state_e state_d;
	logic [31:0] tmr_q;
	logic [31:0] tmr_d;
	pwr_out_s    out_q;
	pwr_out_s    out_d;
	logic        rst_n_q;
	logic        rst_n_d;
	logic        pin_fall;
	logic        pin_toggle;
	logic        i2c_sleep_req;

	assign pin_fall      = pin_q & ~SLEEP_CONTROL_PIN;
	assign pin_toggle    = pin_q ^ SLEEP_CONTROL_PIN;
	assign i2c_sleep_req = pdc_q[BIT_SOURCE_SELECT] & pmc_q[BIT_SLEEP_PERMISSION]
	                     & scmd_q[BIT_SLEEP_REQUEST]; // RULE_20
	assign enter_sleep   = (state_q == P_ACTIVE) && (state_d == P_SLEEP);

	always_comb begin
		state_d = state_q;
		tmr_d   = 32'h0;
		case (state_q) // RULE_10
			P_RESET: begin
				if (VIN_VALID && !VIN_UVLO) begin // RULE_11 RULE_13
					state_d = P_ACTIVE;
				end
			end
			P_ACTIVE: begin
				if (THERMAL_SHUTDOWN) begin // RULE_23
					state_d = P_THERMAL;
				end else if (OUTPUT_FAULT) begin // RULE_22
					state_d = P_FAULT;
				end else if (pdc_q[BIT_SOURCE_SELECT] ? i2c_sleep_req : pin_fall) begin // RULE_18
					state_d = P_SLEEP;
				end
			end
			P_SLEEP: begin
				if (THERMAL_SHUTDOWN) begin
					state_d = P_THERMAL;
				end else if (pin_toggle) begin // RULE_21
					state_d = P_ACTIVE;
				end
			end
			P_FAULT: begin
				tmr_d = tmr_q + 32'h1;
				if (THERMAL_SHUTDOWN) begin
					state_d = P_THERMAL;
				end else if (tmr_q >= 32'(RETRY_CYCLES - 1)) begin // RULE_22
					state_d = P_ACTIVE;
				end
			end
			P_THERMAL: begin
				if (!THERMAL_SHUTDOWN) begin
					state_d = P_RESET;
				end
			end
			default: begin
				state_d = P_RESET;
			end
		endcase
		if (state_q != P_RESET && VIN_UVLO) begin // RULE_14
			state_d = P_RESET;
			tmr_d   = 32'h0;
		end
	end

	// Outputs follow the next state so they line up with the state register
	always_comb begin
		out_d.reg_enable  = '0;
		out_d.alt_voltage = '0;
		out_d.seq_start   = 1'b0;
		rst_n_d           = 1'b0; // RULE_11 RULE_22 RULE_23
		case (state_d)
			P_ACTIVE: begin
				out_d.reg_enable = '1;
				out_d.seq_start  = (state_q != P_ACTIVE) && (state_q != P_SLEEP); // RULE_15
				rst_n_d          = 1'b1;
			end
			P_SLEEP: begin
				out_d.reg_enable  = slp_en_q; // RULE_16
				out_d.alt_voltage = slp_alt_q & slp_en_q[NUM_BUCK-1:0]; // RULE_17
				rst_n_d           = 1'b1;
			end
			default: begin
				out_d.reg_enable = '0;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			state_q <= P_RESET;
			tmr_q   <= 32'h0;
			out_q   <= '0;
			rst_n_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tmr_q   <= tmr_d;
			out_q   <= out_d;
			rst_n_q <= rst_n_d;
		end
	end

	assign PWR_OUT             = out_q;
	assign MAIN_RESET_OUT_N    = rst_n_q;
	assign AUX_RESET_ONE_OUT_N = rst_n_q;
	assign AUX_RESET_TWO_OUT_N = rst_n_q;
	assign POWER_STATE         = state_q;

endmodule

`default_nettype wire

// File: power_state_i2c_slave_properties.sv
// Port checks for the power-state controller
`timescale 1ns/100ps
`default_nettype none
module power_state_i2c_slave_properties #(
	parameter int RETRY_CYCLES = power_state_pkg::RETRY_CYC
) (
	// Clock and reset
	input wire logic                      CLK_SYS,
	input wire logic                      RST,
	// Watched ports
	input wire logic                      SDA_O,
	input wire logic                      SDA_OE,
	input wire logic                      VIN_VALID,
	input wire logic                      VIN_UVLO,
	input wire logic                      THERMAL_SHUTDOWN,
	input wire power_state_pkg::pwr_out_s PWR_OUT,
	input wire logic                      MAIN_RESET_OUT_N,
	input wire logic                      AUX_RESET_ONE_OUT_N,
	input wire logic                      AUX_RESET_TWO_OUT_N,
	input wire logic [2:0]                POWER_STATE
);
	import power_state_pkg::*;
	logic [31:0] fault_cnt_q;
	logic [31:0] fault_cnt_d;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	// ----------------------------------------------------------------
	// Cycles spent in the fault state
	// ----------------------------------------------------------------
	always_comb fault_cnt_d = (POWER_STATE == 3'h3) ? fault_cnt_q + 32'h1 : 32'h0;
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			fault_cnt_q <= 32'h0;
		end else begin
			fault_cnt_q <= fault_cnt_d;
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_open_drain: assert property (!SDA_O)
		else $error("SDA output value not low");
	a_legal_state: assert property (POWER_STATE <= 3'h4)
		else $error("illegal power state");
	a_engine_off: assert property (
		(POWER_STATE != 3'h1) && ($past(POWER_STATE) != 3'h1) |-> !SDA_OE)
		else $error("SDA pulled outside active state");
	a_outputs_off: assert property (
		POWER_STATE inside {3'h0, 3'h3, 3'h4} |-> !MAIN_RESET_OUT_N && !AUX_RESET_ONE_OUT_N
		&& !AUX_RESET_TWO_OUT_N && PWR_OUT == '0)
		else $error("outputs not off in reset, fault or thermal");
	a_uvlo_return: assert property (
		VIN_UVLO && POWER_STATE != 3'h0 |=> POWER_STATE == 3'h0)
		else $error("lockout did not return to reset");
	a_valid_start: assert property (
		POWER_STATE == 3'h0 && VIN_VALID && !VIN_UVLO |=> POWER_STATE == 3'h1)
		else $error("valid input did not start active");
	a_boot_sequenced: assert property (
		$past(POWER_STATE) == 3'h0 && POWER_STATE == 3'h1 |-> PWR_OUT.seq_start
		&& PWR_OUT.reg_enable == 7'h7f && MAIN_RESET_OUT_N)
		else $error("start from reset not sequenced");
	a_wake_unsequenced: assert property (
		$past(POWER_STATE) == 3'h2 && POWER_STATE == 3'h1 |-> !PWR_OUT.seq_start)
		else $error("wake from sleep was sequenced");
	a_seq_single: assert property (PWR_OUT.seq_start |=> !PWR_OUT.seq_start)
		else $error("sequence start longer than one cycle");
	a_sleep_outs: assert property (
		POWER_STATE == 3'h2 |-> MAIN_RESET_OUT_N && AUX_RESET_ONE_OUT_N && AUX_RESET_TWO_OUT_N
		&& (PWR_OUT.alt_voltage & ~PWR_OUT.reg_enable[3:0]) == 4'h0)
		else $error("sleep outputs inconsistent");
	a_thermal_entry: assert property (
		THERMAL_SHUTDOWN && POWER_STATE == 3'h1 && !VIN_UVLO |=> POWER_STATE == 3'h4)
		else $error("thermal event not taken");
	a_fault_retry: assert property (
		$past(POWER_STATE) == 3'h3 && POWER_STATE == 3'h1
		|-> fault_cnt_q inside {[RETRY_CYCLES-2:RETRY_CYCLES]})
		else $error("fault retry at wrong time");
	a_fault_bound: assert property (fault_cnt_q <= RETRY_CYCLES)
		else $error("fault state held too long");
endmodule
`default_nettype wire

// File: i2c_host_model.sv
// I2C host model driving the serial port of the block
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model (
	// Clock and wire level
	input  wire logic clk,
	input  wire logic sda,
	// Driven lines
	output var  logic scl,
	output var  logic pull
);
	logic glitch = 1'b0;
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Twelve-cycle phases stay clear of the input filter delay
	task automatic bit_io(input logic b, output logic r);
		pull <= !b;
		hold(6);
		scl <= 1'b1;
		hold(3);
		if (glitch) begin
			scl <= 1'b0;
			hold(2);
			scl <= 1'b1;
		end
		hold(3);
		@(negedge clk) r = sda;
		hold(6);
		scl <= 1'b0;
		hold(6);
	endtask
	task automatic start_c();
		pull <= 1'b0;
		hold(6);
		scl <= 1'b1;
		hold(6);
		pull <= 1'b1;
		hold(6);
		scl <= 1'b0;
		hold(6);
	endtask
	task automatic stop_c();
		pull <= 1'b1;
		hold(6);
		scl <= 1'b1;
		hold(6);
		pull <= 1'b0;
		hold(6);
	endtask
	task automatic byte_io(input logic [7:0] b, input logic m, output logic [7:0] r,
		output logic k);
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r[i]);
		end
		bit_io(m, k);
	endtask
	task automatic reg_wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] v,
		output logic ok);
		logic [7:0] r;
		logic [2:0] k;
		start_c();
		byte_io({a, 1'b0}, 1'b1, r, k[0]);
		byte_io(idx, 1'b1, r, k[1]);
		byte_io(v, 1'b1, r, k[2]);
		stop_c();
		ok = (k === 3'b000);
	endtask
	task automatic reg_rd(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] d,
		output logic ok);
		logic [7:0] r;
		logic [2:0] k;
		logic       n;
		start_c();
		byte_io({a, 1'b0}, 1'b1, r, k[0]);
		byte_io(idx, 1'b1, r, k[1]);
		start_c();
		byte_io({a, 1'b1}, 1'b1, r, k[2]);
		byte_io(8'hff, 1'b1, d, n);
		stop_c();
		ok = (k === 3'b000);
	endtask
endmodule
`default_nettype wire

// File: power_state_i2c_slave_bench.sv
// Register-level bench of the power-state controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
bind power_state_i2c_slave power_state_i2c_slave_properties #(
	.RETRY_CYCLES(RETRY_CYCLES)
) power_state_i2c_slave_properties_inst (
	.CLK_SYS, .RST, .SDA_O, .SDA_OE, .VIN_VALID, .VIN_UVLO, .THERMAL_SHUTDOWN, .PWR_OUT,
	.MAIN_RESET_OUT_N, .AUX_RESET_ONE_OUT_N, .AUX_RESET_TWO_OUT_N, .POWER_STATE
);
module power_state_i2c_slave_bench;
	import power_state_pkg::*;
	logic         clk, rst, vin_valid, vin_uvlo, out_fault, thermal, pin;
	logic         scl, pull, sda_w, sda_o, sda_oe, main_n, aux1_n, aux2_n, ok;
	logic [2:0]   st;
	logic [7:0]   d;
	pwr_out_s     pwr;
	factory_cfg_s fcfg;
	int           err_count, tests_run;
	// Open-drain wire with pull-up
	assign sda_w = !(sda_oe || pull);
	power_state_i2c_slave #(.RETRY_CYCLES(20)) power_state_i2c_slave_inst (
		.CLK_SYS(clk), .RST(rst), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE(sda_oe),
		.VIN_VALID(vin_valid), .VIN_UVLO(vin_uvlo), .OUTPUT_FAULT(out_fault),
		.THERMAL_SHUTDOWN(thermal), .SLEEP_CONTROL_PIN(pin), .FACTORY_CFG(fcfg), .PWR_OUT(pwr),
		.MAIN_RESET_OUT_N(main_n), .AUX_RESET_ONE_OUT_N(aux1_n), .AUX_RESET_TWO_OUT_N(aux2_n),
		.POWER_STATE(st)
	);
	i2c_host_model i2c_host_model_inst (.clk(clk), .sda(sda_w), .scl(scl), .pull(pull));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic wait_st(input logic [2:0] s);
		int i;
		i = 0;
		do begin
			@(negedge clk);
			i++;
		end while (st !== s && i < 200);
		`CHK(st, s)
		// Hand back on a rising edge so the next stimulus lands there
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		i2c_host_model_inst.reg_rd(DEV_ADDR, idx, d, ok);
		`CHK(ok, 1'b1)
		`CHK(d, e)
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		i2c_host_model_inst.reg_wr(DEV_ADDR, idx, v, ok);
		`CHK(ok, 1'b1)
	endtask
	// ----------------------------------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		report_and_stop();
	end
	initial begin
		rst = 1'b1;
		vin_valid = 1'b0;
		vin_uvlo = 1'b0;
		out_fault = 1'b0;
		thermal = 1'b0;
		pin = 1'b1;
		fcfg = '{power_down_config: 8'h00, sleep_out_enable: 7'h55, sleep_alt_select: 4'h3};
		err_count = 0;
		tests_run = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		wait_st(P_RESET);
		`CHK({main_n, aux1_n, aux2_n, pwr}, 15'h0)
		vin_valid <= 1'b1;
		wait_st(P_ACTIVE);
		`CHK(pwr.reg_enable, 7'h7f)
		rd(OFS_SLEEP_OUT_ENABLE, 8'h55);
		rd(OFS_SLEEP_ALT_SELECT, 8'h03);
		rd(OFS_POWER_MODE_CONTROL, RST_POWER_MODE_CONTROL);
		rd(OFS_SLEEP_COMMAND, RST_SLEEP_COMMAND);
		rd(OFS_POWER_STATUS, 8'h01);
		rd(8'h05, 8'h00);
		i2c_host_model_inst.reg_wr(7'h5b, 8'h00, 8'h01, ok);
		`CHK(ok, 1'b0)
		rd(OFS_POWER_MODE_CONTROL, 8'h00);
		i2c_host_model_inst.glitch = 1'b1;
		wr(OFS_POWER_MODE_CONTROL, 8'h01);
		i2c_host_model_inst.glitch = 1'b0;
		// Abandoned packet, then a fresh start must begin over
		i2c_host_model_inst.start_c();
		i2c_host_model_inst.byte_io(8'hb4, 1'b1, d, ok);
		i2c_host_model_inst.byte_io(OFS_POWER_DOWN_CONFIG, 1'b1, d, ok);
		i2c_host_model_inst.reg_rd(DEV_ADDR, OFS_POWER_DOWN_CONFIG, d, ok);
		`CHK(ok, 1'b1)
		`CHK(d, 8'h00)
		wr(OFS_POWER_DOWN_CONFIG, d | 8'h02);
		rd(OFS_POWER_DOWN_CONFIG, 8'h02);
		i2c_host_model_inst.reg_wr(DEV_ADDR, OFS_SLEEP_COMMAND, 8'h02, ok);
		wait_st(P_SLEEP);
		`CHK(pwr, {7'h55, 4'h1, 1'b0})
		`CHK({main_n, aux1_n, aux2_n}, 3'b111)
		i2c_host_model_inst.reg_rd(DEV_ADDR, OFS_POWER_STATUS, d, ok);
		`CHK(ok, 1'b0)
		pin <= 1'b0;
		wait_st(P_ACTIVE);
		rd(OFS_SLEEP_COMMAND, 8'h00);
		pin <= 1'b1;
		wr(OFS_POWER_DOWN_CONFIG, 8'h00);
		`CHK(st, P_ACTIVE)
		pin <= 1'b0;
		wait_st(P_SLEEP);
		pin <= 1'b1;
		wait_st(P_ACTIVE);
		out_fault <= 1'b1;
		wait_st(P_FAULT);
		wait_st(P_ACTIVE);
		wait_st(P_FAULT);
		out_fault <= 1'b0;
		wait_st(P_ACTIVE);
		thermal <= 1'b1;
		wait_st(P_THERMAL);
		`CHK({main_n, pwr}, 13'h0)
		i2c_host_model_inst.reg_rd(DEV_ADDR, OFS_POWER_STATUS, d, ok);
		`CHK(ok, 1'b0)
		thermal <= 1'b0;
		wait_st(P_ACTIVE);
		rd(OFS_POWER_MODE_CONTROL, RST_POWER_MODE_CONTROL);
		wr(OFS_SLEEP_ALT_SELECT, 8'h0f);
		vin_uvlo <= 1'b1;
		wait_st(P_RESET);
		vin_uvlo <= 1'b0;
		wait_st(P_ACTIVE);
		rd(OFS_SLEEP_ALT_SELECT, 8'h03);
		report_and_stop();
	end
endmodule
`default_nettype wire
